/* File: vram_ctrl_consts.svh */
// Constants of the video RAM controller: register offsets, field
// positions, reset values and timing counts.
// Assumes a 25 MHz controller clock.
`ifndef VRAM_CTRL_CONSTS_SVH
`define VRAM_CTRL_CONSTS_SVH

// Register byte offsets.
`define OFS_CMD        8'h00
`define OFS_ADDR       8'h04
`define OFS_WDATA      8'h08
`define OFS_STATUS     8'h0c
`define OFS_CTRL       8'h10

// Field positions.
`define CMD_OP_LSB     0
`define ADDR_COL_LSB   16
`define WDATA_CODE_LSB 8
`define ST_BUSY        0
`define ST_WMODE       1
`define ST_REFPEND     2
`define ST_DROPPED     3
`define ST_RDATA_LSB   8
`define CTRL_AUTOREF   0
`define CTRL_SE_N      1

// Reset values.
`define RST_AUTOREF    1'b1
`define RST_SE_N       1'b0

// Timing, printed units and derived cycle counts.
`define CLK_NS         40
`define RAS_LOW_NS     100
`define PRECH_NS       120
`define CAS_LOW_NS     120
`define SETUP_NS       40
`define SC_HIGH_NS     40
`define SC_LOW_NS      120
`define REFRESH_MS     8
`define REFRESH_ROWS   512
`define RAS_LOW_CYC    ((`RAS_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define PRECH_CYC      ((`PRECH_NS + `CLK_NS - 1) / `CLK_NS)
`define CAS_LOW_CYC    ((`CAS_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC      ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define SC_HIGH_CYC    ((`SC_HIGH_NS + `CLK_NS - 1) / `CLK_NS)
`define SC_LOW_CYC     ((`SC_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define REF_INT_CYC    ((`REFRESH_MS * 1000000) / `REFRESH_ROWS / `CLK_NS)

`endif

/* File: vram_ctrl_pkg.sv */
// Types of the video RAM controller.
// Assumes nothing of its surroundings.
package vram_ctrl_pkg;

  // Sequencer states, Gray coded along the strobe path.
  typedef enum logic [2:0] {
    st_idle    = 3'h0,
    st_setup   = 3'h1,
    st_ras_low = 3'h3,
    st_cas_low = 3'h2,
    st_dt_rise = 3'h6,
    st_prech   = 3'h7,
    st_sc_high = 3'h5,
    st_sc_low  = 3'h4
  } state_t;

  // Operations that software can order.
  typedef enum logic [2:0] {
    op_ras_refresh = 3'h0,
    op_counter_refresh = 3'h1,
    op_read_xfer   = 3'h2,
    op_pseudo_xfer = 3'h3,
    op_write_xfer  = 3'h4,
    op_logic_set   = 3'h5,
    op_serial      = 3'h6,
    op_hidden_read = 3'h7
  } op_t;

endpackage : vram_ctrl_pkg

/* File: vram_ctrl.sv */
// Controller that drives a dual-port video RAM through its strobes.
// Assumes an APB master on i_clk and a video RAM on the pin side whose
// returning data pins are asynchronous to i_clk.
`timescale 1ns/1ns
`include "vram_ctrl_consts.svh"

module vram_ctrl (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Video RAM strobes and address.
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic             o_transfer_output_enable_n,
  output logic      [8:0]  o_addr,
  // Random port data pins.
  input  wire logic [7:0]  i_io,
  output logic      [7:0]  o_io,
  output logic             o_io_oe,
  // Serial port pins.
  output logic             o_serial_shift_clock,
  output logic             o_serial_enable_n,
  input  wire logic [7:0]  i_sio,
  output logic      [7:0]  o_sio,
  output logic             o_sio_oe
);

  //////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [8:0]  row;
  logic [7:0]  col;
  logic [7:0]  wbyte;
  logic [3:0]  code;
  logic        auto_ref;
  logic        se_level;
  logic [7:0]  rdata;
  logic        wmode;
  logic        ref_pend;
  logic        dropped;
  logic        cmd_pend;
  logic [2:0]  cmd_op;
  vram_ctrl_pkg::state_t state;
  logic [8:0]  next_row;
  logic [7:0]  next_col;
  logic [7:0]  next_wbyte;
  logic [3:0]  next_code;
  logic        next_auto_ref;
  logic        next_se_level;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setup_ph;
  logic        wr_take;
  logic        cmd_wr;
  logic        st_wr;

  // A write is taken only at the edge that completes its access phase.
  assign setup_ph = i_psel & ~i_penable;
  assign wr_take  = i_psel & i_penable & o_pready & i_pwrite;
  assign cmd_wr   = wr_take & (i_paddr == `OFS_CMD);
  assign st_wr    = wr_take & (i_paddr == `OFS_STATUS);

  // Read data and the answer are prepared during the setup cycle.
  always_comb
  begin
    next_row      = row;
    next_col      = col;
    next_wbyte    = wbyte;
    next_code     = code;
    next_auto_ref = auto_ref;
    next_se_level = se_level;
    next_prdata   = 32'h0;
    next_pready   = setup_ph;
    next_pslverr  = 1'b0;
    if (setup_ph)
    begin
      if (i_paddr == `OFS_CMD)
        next_prdata[`CMD_OP_LSB +: 3] = cmd_op;
      else if (i_paddr == `OFS_ADDR)
      begin
        next_prdata[8:0] = row;
        next_prdata[`ADDR_COL_LSB +: 8] = col;
      end
      else if (i_paddr == `OFS_WDATA)
      begin
        next_prdata[7:0] = wbyte;
        next_prdata[`WDATA_CODE_LSB +: 4] = code;
      end
      else if (i_paddr == `OFS_STATUS)
      begin
        next_prdata[`ST_BUSY]    = (state != vram_ctrl_pkg::st_idle)
                                   | cmd_pend;
        next_prdata[`ST_WMODE]   = wmode;
        next_prdata[`ST_REFPEND] = ref_pend;
        next_prdata[`ST_DROPPED] = dropped;
        next_prdata[`ST_RDATA_LSB +: 8] = rdata;
      end
      else if (i_paddr == `OFS_CTRL)
      begin
        next_prdata[`CTRL_AUTOREF] = auto_ref;
        next_prdata[`CTRL_SE_N]    = se_level;
      end
      else
        next_pslverr = 1'b1;
    end
    if (wr_take && i_paddr == `OFS_ADDR)
    begin
      next_row = i_pwdata[8:0];
      next_col = i_pwdata[`ADDR_COL_LSB +: 8];
    end
    if (wr_take && i_paddr == `OFS_WDATA)
    begin
      next_wbyte = i_pwdata[7:0];
      next_code  = i_pwdata[`WDATA_CODE_LSB +: 4];
    end
    if (wr_take && i_paddr == `OFS_CTRL)
    begin
      next_auto_ref = i_pwdata[`CTRL_AUTOREF];
      next_se_level = i_pwdata[`CTRL_SE_N];
    end
  end

  // Bus registers.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      row       <= 9'h0;
      col       <= 8'h0;
      wbyte     <= 8'h0;
      code      <= 4'h0;
      auto_ref  <= `RST_AUTOREF;
      se_level  <= `RST_SE_N;
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      row       <= next_row;
      col       <= next_col;
      wbyte     <= next_wbyte;
      code      <= next_code;
      auto_ref  <= next_auto_ref;
      se_level  <= next_se_level;
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage is read by the second only.

  logic [7:0] io_m;
  logic [7:0] io_s;
  logic [7:0] sio_m;
  logic [7:0] sio_s;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      io_m  <= 8'h0;
      io_s  <= 8'h0;
      sio_m <= 8'h0;
      sio_s <= 8'h0;
    end
    else
    begin
      io_m  <= i_io;
      io_s  <= io_m;
      sio_m <= i_sio;
      sio_s <= sio_m;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Strobe sequencer and refresh timer.

  vram_ctrl_pkg::op_t    op;
  vram_ctrl_pkg::op_t    next_op;
  vram_ctrl_pkg::state_t next_state;
  logic [3:0]  timer;
  logic [3:0]  next_timer;
  logic [9:0]  ref_cnt;
  logic [9:0]  next_ref_cnt;
  logic        next_ref_pend;
  logic        next_cmd_pend;
  logic [2:0]  next_cmd_op;
  logic        next_dropped;
  logic [7:0]  next_rdata;
  logic        next_wmode;
  logic        next_ras_n;
  logic        next_cas_n;
  logic        next_we_n;
  logic        next_dtoe_n;
  logic [8:0]  next_addr;
  logic [7:0]  next_io;
  logic        next_io_oe;
  logic        next_sc;
  logic        next_se_n;
  logic [7:0]  next_sio;
  logic        next_sio_oe;
  logic        done;

  assign done = (timer == 4'h0);

  // Every phase lasts a whole number of clocks; the sequencer trades some
  // speed for margin because the device sees only 40 ns steps.
  always_comb
  begin
    next_state    = state;
    next_op       = op;
    next_timer    = done ? 4'h0 : timer - 4'h1;
    next_ref_cnt  = ref_cnt;
    next_ref_pend = ref_pend;
    next_cmd_pend = cmd_pend;
    next_cmd_op   = cmd_op;
    next_dropped  = dropped & ~(st_wr & i_pwdata[`ST_DROPPED]);
    next_rdata    = rdata;
    next_wmode    = wmode;
    next_ras_n    = o_ras_n;
    next_cas_n    = o_cas_n;
    next_we_n     = o_we_n;
    next_dtoe_n   = o_transfer_output_enable_n;
    next_addr     = o_addr;
    next_io       = o_io;
    next_io_oe    = o_io_oe;
    next_sc       = o_serial_shift_clock;
    next_se_n     = o_serial_enable_n;
    next_sio      = o_sio;
    next_sio_oe   = o_sio_oe;
    // Refresh interval timer; its set wins over the launch that clears.
    if (auto_ref)
    begin
      if (ref_cnt == 10'h0)
        next_ref_cnt = 10'(`REF_INT_CYC - 1);
      else
        next_ref_cnt = ref_cnt - 10'h1;
    end
    // A command written while one is still waiting is dropped and flagged.
    if (cmd_wr)
    begin
      if (cmd_pend)
        next_dropped = 1'b1;
      else
      begin
        next_cmd_pend = 1'b1;
        next_cmd_op   = i_pwdata[`CMD_OP_LSB +: 3];
      end
    end
    case (state)
      vram_ctrl_pkg::st_idle:
      begin
        // Serial work starts only from idle, never while RAS is low.
        if (ref_pend || cmd_pend)
        begin
          if (ref_pend)
          begin
            next_op       = vram_ctrl_pkg::op_counter_refresh;
            next_ref_pend = 1'b0;
          end
          else
          begin
            next_op       = vram_ctrl_pkg::op_t'(cmd_op);
            next_cmd_pend = cmd_wr & ~cmd_pend;
          end
          next_state = vram_ctrl_pkg::st_setup;
          next_timer = 4'(`SETUP_CYC - 1);
          next_addr  = row;
          next_dtoe_n = 1'b1;
          next_we_n  = 1'b1;
          next_cas_n = 1'b1;
          case (ref_pend ? vram_ctrl_pkg::op_counter_refresh
                         : vram_ctrl_pkg::op_t'(cmd_op))
            vram_ctrl_pkg::op_counter_refresh:
              next_cas_n = 1'b0;
            vram_ctrl_pkg::op_read_xfer:
            begin
              next_dtoe_n = 1'b0;
              next_sio_oe = 1'b0;
            end
            vram_ctrl_pkg::op_pseudo_xfer:
            begin
              next_dtoe_n = 1'b0;
              next_we_n   = 1'b0;
              next_se_n   = 1'b1;
              next_sio_oe = 1'b0;
            end
            vram_ctrl_pkg::op_write_xfer:
            begin
              next_dtoe_n = 1'b0;
              next_we_n   = 1'b0;
              next_se_n   = 1'b0;
            end
            vram_ctrl_pkg::op_logic_set:
            begin
              next_cas_n = 1'b0;
              next_we_n  = 1'b0;
              next_addr  = {5'h0, code};
              next_io    = wbyte;
              next_io_oe = 1'b1;
            end
            vram_ctrl_pkg::op_serial:
            begin
              next_se_n   = se_level;
              next_sio    = wbyte;
              next_sio_oe = wmode;
            end
            default:
              next_dtoe_n = 1'b1;
          endcase
        end
        if (ref_pend && cmd_wr && !cmd_pend)
          next_cmd_pend = 1'b1;
      end
      vram_ctrl_pkg::st_setup:
        if (done)
        begin
          next_timer = 4'(`RAS_LOW_CYC - 1);
          if (op == vram_ctrl_pkg::op_serial)
          begin
            next_state = vram_ctrl_pkg::st_sc_high;
            next_sc    = 1'b1;
            next_timer = 4'(`SC_HIGH_CYC - 1);
          end
          else
          begin
            next_state = vram_ctrl_pkg::st_ras_low;
            next_ras_n = 1'b0;
          end
        end
      vram_ctrl_pkg::st_ras_low:
        if (done)
        begin
          if (op == vram_ctrl_pkg::op_logic_set)
            next_io_oe = 1'b0;
          if (op >= vram_ctrl_pkg::op_read_xfer &&
              op != vram_ctrl_pkg::op_logic_set &&
              op != vram_ctrl_pkg::op_serial && o_cas_n)
          begin
            next_state = vram_ctrl_pkg::st_cas_low;
            next_timer = 4'(`CAS_LOW_CYC - 1);
            next_cas_n = 1'b0;
            next_addr  = {1'b0, col};
            if (op == vram_ctrl_pkg::op_hidden_read)
              next_dtoe_n = 1'b0;
          end
          else
          begin
            // Ends refresh, set/reset and the hidden refresh pass.
            next_state  = vram_ctrl_pkg::st_prech;
            next_timer  = 4'(`PRECH_CYC - 1);
            next_ras_n  = 1'b1;
            next_cas_n  = 1'b1;
            next_we_n   = 1'b1;
            next_dtoe_n = 1'b1;
          end
        end
      vram_ctrl_pkg::st_cas_low:
        if (done)
        begin
          next_timer = 4'(`PRECH_CYC - 1);
          if (op == vram_ctrl_pkg::op_read_xfer)
          begin
            next_state  = vram_ctrl_pkg::st_dt_rise;
            next_dtoe_n = 1'b1;
            next_wmode  = 1'b0;
          end
          else if (op == vram_ctrl_pkg::op_hidden_read)
          begin
            // Column strobe and output enable stay low across the gap.
            next_state = vram_ctrl_pkg::st_prech;
            next_rdata = io_s;
            next_ras_n = 1'b1;
          end
          else
          begin
            next_state  = vram_ctrl_pkg::st_prech;
            next_wmode  = 1'b1;
            next_ras_n  = 1'b1;
            next_cas_n  = 1'b1;
            next_we_n   = 1'b1;
            next_dtoe_n = 1'b1;
            next_se_n   = 1'b1;
          end
        end
      vram_ctrl_pkg::st_dt_rise:
        if (done)
        begin
          next_state = vram_ctrl_pkg::st_prech;
          next_ras_n = 1'b1;
          next_cas_n = 1'b1;
        end
      vram_ctrl_pkg::st_prech:
        if (done)
        begin
          if (!o_cas_n)
          begin
            next_state = vram_ctrl_pkg::st_ras_low;
            next_timer = 4'(`RAS_LOW_CYC - 1);
            next_ras_n = 1'b0;
          end
          else
            next_state = vram_ctrl_pkg::st_idle;
        end
      vram_ctrl_pkg::st_sc_high:
        if (done)
        begin
          next_state = vram_ctrl_pkg::st_sc_low;
          next_timer = 4'(`SC_LOW_CYC - 1);
          next_sc    = 1'b0;
        end
      default:
        if (done)
        begin
          // The low phase covers the pin synchroniser latency.
          if (!wmode)
            next_rdata = sio_s;
          next_sio_oe = 1'b0;
          next_se_n   = 1'b1;
          next_state  = vram_ctrl_pkg::st_idle;
        end
    endcase
    if (auto_ref && ref_cnt == 10'h0)
      next_ref_pend = 1'b1;
  end

  // Sequencer registers.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state    <= vram_ctrl_pkg::st_idle;
      op       <= vram_ctrl_pkg::op_ras_refresh;
      timer    <= 4'h0;
      ref_cnt  <= 10'h0;
      ref_pend <= 1'b0;
      cmd_pend <= 1'b0;
      cmd_op   <= 3'h0;
      dropped  <= 1'b0;
      rdata    <= 8'h0;
      wmode    <= 1'b0;
      o_ras_n  <= 1'b1;
      o_cas_n  <= 1'b1;
      o_we_n   <= 1'b1;
      o_transfer_output_enable_n <= 1'b1;
      o_addr   <= 9'h0;
      o_io     <= 8'h0;
      o_io_oe  <= 1'b0;
      o_serial_shift_clock <= 1'b0;
      o_serial_enable_n    <= 1'b1;
      o_sio    <= 8'h0;
      o_sio_oe <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      op       <= next_op;
      timer    <= next_timer;
      ref_cnt  <= next_ref_cnt;
      ref_pend <= next_ref_pend;
      cmd_pend <= next_cmd_pend;
      cmd_op   <= next_cmd_op;
      dropped  <= next_dropped;
      rdata    <= next_rdata;
      wmode    <= next_wmode;
      o_ras_n  <= next_ras_n;
      o_cas_n  <= next_cas_n;
      o_we_n   <= next_we_n;
      o_transfer_output_enable_n <= next_dtoe_n;
      o_addr   <= next_addr;
      o_io     <= next_io;
      o_io_oe  <= next_io_oe;
      o_serial_shift_clock <= next_sc;
      o_serial_enable_n    <= next_se_n;
      o_sio    <= next_sio;
      o_sio_oe <= next_sio_oe;
    end
  end

endmodule : vram_ctrl

/* File: vram_model.sv */
// Behavioural dual-port video RAM that answers the controller's strobes.
// Assumes the bench resolves the shared data pins before they reach it.
`timescale 1ns/1ns
module vram_model (
  // Strobes and address.
  input  wire logic       i_ras_n,
  input  wire logic       i_cas_n,
  input  wire logic       i_we_n,
  input  wire logic       i_dt_n,
  input  wire logic [8:0] i_addr,
  input  wire logic       i_sc,
  input  wire logic       i_se_n,
  // Resolved data pins.
  input  wire logic [7:0] i_io,
  input  wire logic [7:0] i_sio,
  // Device drive; a released pin shows the inverse of its last byte.
  output logic      [7:0] o_io,
  output logic      [7:0] o_sio
);
  logic [7:0] mem [512][256];
  logic [7:0] sbuf [256];
  logic [7:0] ptr, col, mask, sbyte, wd, wm, tmask;
  logic [8:0] row;
  logic [3:0] lcode;
  logic       lmode, wmode, rd_xfer, wx, rd_cyc, tmask_on;
  int         cbr_cnt;
  // Stored result of a logic-mode write; code 5 passes the input through.
  function automatic logic [7:0] lop(input logic [3:0] k,
                                     input logic [7:0] d,
                                     input logic [7:0] m);
    case (k)
      4'h0: return 8'h00;
      4'h1: return d & m;
      4'h2: return ~d & m;
      4'h3: return m;
      4'h4: return d & ~m;
      4'h5: return d;
      4'h6: return d ^ m;
      4'h7: return d | m;
      4'h8: return ~(d | m);
      4'h9: return ~(d ^ m);
      4'ha: return ~d;
      4'hb: return ~d | m;
      4'hc: return ~m;
      4'hd: return d | ~m;
      4'he: return ~(d & m);
      default: return 8'hff;
    endcase
  endfunction : lop
  // Known contents let the bench predict every byte.
  initial
  begin
    for (int r = 0; r < 512; r++)
      for (int c = 0; c < 256; c++)
        mem[r][c] = 8'(r) ^ 8'(c);
    {lmode, wmode, rd_xfer, wx, rd_cyc, ptr, col, sbyte, row} = '0;
    tmask_on = 1'b0;
    mask     = 8'hff;
    cbr_cnt = 0;
  end
  // The cycle kind is decoded from the strobes at row strobe fall.
  always @(negedge i_ras_n)
  begin
    if (!i_cas_n)
    begin
      cbr_cnt++;
      if (!i_we_n)
      begin
        lcode = i_addr[3:0];
        lmode = (i_addr[3:0] != 4'h5);
        mask  = i_io;
      end
    end
    else if (!i_dt_n && i_we_n)
    begin
      row     = i_addr;
      rd_xfer = 1'b1;
    end
    else if (!i_dt_n)
    begin
      wmode = 1'b1;
      wx    = 1'b1;
      if (!i_se_n)
        mem[i_addr] = sbuf;
    end
    else
    begin
      row    = i_addr;
      rd_cyc = 1'b1;
      tmask_on = !i_we_n;
      tmask    = i_io;
    end
  end
  // Column address; the read data stays while column strobe stays low.
  // A write with the transfer input high is masked and may be combined.
  always @(negedge i_cas_n)
    if (!i_ras_n)
    begin
      col = i_addr[7:0];
      if (!i_we_n && i_dt_n)
      begin
        wd = lop(lmode && !tmask_on ? lcode : 4'h5, i_io,
                 mem[row][col]);
        wm = tmask_on ? tmask : mask;
        mem[row][col] = (wd & wm) | (mem[row][col] & ~wm);
      end
    end
  always @(posedge i_cas_n)
    rd_cyc = 1'b0;
  // The start position of a write-side transfer applies after the cycle.
  always @(posedge i_ras_n)
  begin
    if (wx)
      ptr = col;
    wx = 1'b0;
  end
  // A read transfer copies the row when the transfer input rises.
  always @(posedge i_dt_n)
    if (rd_xfer && !i_ras_n)
    begin
      sbuf    = mem[row];
      ptr     = col;
      wmode   = 1'b0;
      rd_xfer = 1'b0;
    end
  // The pointer advances on every clock rise, masked or not.
  always @(posedge i_sc)
  begin
    if (wmode && !i_se_n)
      sbuf[ptr] = i_sio;
    sbyte = sbuf[ptr];
    ptr++;
  end
  assign o_io  = (rd_cyc && !i_cas_n && !i_dt_n) ? mem[row][col]
                                                 : ~mem[row][col];
  assign o_sio = (!wmode && !i_se_n) ? sbyte : ~sbyte;
endmodule : vram_model

/* File: vram_ctrl_checker.sv */
// Checker of the controller's strobe and serial pin sequencing.
// Assumes it is bound to vram_ctrl and sees only its ports.
`timescale 1ns/1ns
module vram_ctrl_checker (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Observed pins.
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n,
  input wire logic o_transfer_output_enable_n,
  input wire logic o_io_oe,
  input wire logic o_serial_shift_clock,
  input wire logic o_sio_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Transfers start at a row strobe fall with the column strobe high.
  sequence s_rd_xfer;
    $fell(o_ras_n) && o_cas_n && !o_transfer_output_enable_n && o_we_n;
  endsequence
  sequence s_wr_xfer;
    $fell(o_ras_n) && o_cas_n && !o_transfer_output_enable_n && !o_we_n;
  endsequence
  a_sc_ras_high: assert property (o_serial_shift_clock |-> o_ras_n)
    else $error("serial clock high while row strobe low");
  a_sc_one_pulse: assert property ($rose(o_serial_shift_clock) |=>
    !o_serial_shift_clock) else $error("serial clock pulse too long");
  a_rd_sio_free: assert property (s_rd_xfer |-> !o_sio_oe)
    else $error("serial pins driven into a read transfer");
  a_rd_copy_edge: assert property (s_rd_xfer |-> ##[1:8]
    ($rose(o_transfer_output_enable_n) && !o_ras_n))
    else $error("transfer input did not rise with row strobe low");
  a_wr_col_fall: assert property (s_wr_xfer |-> ##[1:6] $fell(o_cas_n))
    else $error("no column address in write side transfer");
  a_wr_sc_quiet: assert property (s_wr_xfer |->
    (!o_serial_shift_clock)[*8]) else $error("serial clock in transfer");
  a_set_mask_on: assert property ($fell(o_ras_n) && !o_cas_n &&
    !o_we_n |-> o_io_oe) else $error("mask not driven in set cycle");
  a_cbr_io_free: assert property ($fell(o_ras_n) && !o_cas_n &&
    o_we_n |-> !o_io_oe) else $error("data pins driven in refresh");
endmodule : vram_ctrl_checker
bind vram_ctrl vram_ctrl_checker vram_ctrl_checker_i (.*);

/* File: vram_ctrl_test.sv */
// Testbench of the video RAM controller, ordered over APB.
// Assumes the behavioural device model and the bound checker.
`timescale 1ns/1ns
`include "vram_ctrl_consts.svh"
module vram_ctrl_test;
  logic        i_clk, i_rstn, i_psel, i_penable, i_pwrite, slverr;
  logic [7:0]  i_paddr, i_io, o_io, i_sio, o_sio, m_io, m_sio, e;
  logic [31:0] i_pwdata, o_prdata, q;
  logic        o_pready, o_pslverr, o_ras_n, o_cas_n, o_we_n, o_io_oe;
  logic        o_transfer_output_enable_n, o_sio_oe;
  logic        o_serial_shift_clock, o_serial_enable_n;
  logic [8:0]  o_addr;
  int          err_total, checked, cyc, n;
  // Each pin carries whichever party is driving it.
  assign i_io  = o_io_oe ? o_io : m_io;
  assign i_sio = o_sio_oe ? o_sio : m_sio;
  vram_ctrl vram_ctrl_i (.*);
  vram_model vram_model_i (.i_ras_n(o_ras_n), .i_cas_n(o_cas_n),
    .i_we_n(o_we_n), .i_dt_n(o_transfer_output_enable_n),
    .i_addr(o_addr), .i_sc(o_serial_shift_clock),
    .i_se_n(o_serial_enable_n), .i_io(i_io), .i_sio(i_sio),
    .o_io(m_io), .o_sio(m_sio));
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // A hang ends the run through the same verdict.
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // The request stays up until pready; the next setup may follow at once.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd     = o_prdata;
    slverr = o_pslverr;
  endtask : apb
  task automatic rel();
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask : rel
  // Orders one operation and leaves the idle status word in q.
  task automatic cmd(input vram_ctrl_pkg::op_t op, input logic [8:0] r,
                     input logic [7:0] c, input logic [11:0] wd);
    apb(1'b1, `OFS_ADDR, {8'h00, c, 7'h00, r}, q);
    apb(1'b1, `OFS_WDATA, {20'h0, wd}, q);
    apb(1'b1, `OFS_CMD, {29'h0, op}, q);
    rel();
    @(posedge i_clk);
    do apb(1'b0, `OFS_STATUS, 32'h0, q); while (q[0] !== 1'b0);
  endtask : cmd
  task automatic rd_ser(input logic [7:0] exp);
    cmd(vram_ctrl_pkg::op_serial, 9'h0, 8'h0, 12'h0);
    chk({24'h0, q[15:8]}, {24'h0, exp});
  endtask : rd_ser
  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // Main sequence: reset, register checks, then each kind of cycle.
  initial
  begin
    {i_rstn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, `OFS_CTRL, 32'h0, q);
    chk(q, 32'h1);
    apb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    apb(1'b1, `OFS_CTRL, 32'h0, q);
    cmd(vram_ctrl_pkg::op_read_xfer, 9'h1a5, 8'hfe, 12'h0);
    chk({31'h0, q[1]}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      e = 8'hfe + 8'(i);
      rd_ser(8'ha5 ^ e);
    end
    cmd(vram_ctrl_pkg::op_pseudo_xfer, 9'h0, 8'h10, 12'h0);
    chk({31'h0, q[1]}, 32'h1);
    cmd(vram_ctrl_pkg::op_serial, 9'h0, 8'h0, 12'h03c);
    apb(1'b1, `OFS_CTRL, 32'h2, q);
    cmd(vram_ctrl_pkg::op_serial, 9'h0, 8'h0, 12'h0c3);
    apb(1'b1, `OFS_CTRL, 32'h0, q);
    cmd(vram_ctrl_pkg::op_write_xfer, 9'h033, 8'h10, 12'h0);
    chk({31'h0, q[1]}, 32'h1);
    cmd(vram_ctrl_pkg::op_read_xfer, 9'h033, 8'h10, 12'h0);
    rd_ser(8'h3c);
    rd_ser(8'hb4);
    n = vram_model_i.cbr_cnt;
    cmd(vram_ctrl_pkg::op_hidden_read, 9'h077, 8'h21, 12'h0);
    chk({23'h0, vram_model_i.cbr_cnt - n == 1, q[15:8]}, 32'h156);
    apb(1'b0, `OFS_ADDR, 32'h0, q);
    chk(q, 32'h00210077);
    cmd(vram_ctrl_pkg::op_ras_refresh, 9'h155, 8'h0, 12'h0);
    chk({23'h0, vram_model_i.row}, 32'h155);
    n = vram_model_i.cbr_cnt;
    cmd(vram_ctrl_pkg::op_counter_refresh, 9'h0, 8'h0, 12'h0);
    chk(vram_model_i.cbr_cnt - n, 32'h1);
    // Three orders back to back: one runs, one waits, the third drops.
    n = vram_model_i.cbr_cnt;
    apb(1'b1, `OFS_CMD, 32'h1, q);
    apb(1'b1, `OFS_CMD, 32'h1, q);
    apb(1'b1, `OFS_CMD, 32'h1, q);
    rel();
    do apb(1'b0, `OFS_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    chk(vram_model_i.cbr_cnt - n, 32'h2);
    chk({31'h0, q[3]}, 32'h1);
    apb(1'b1, `OFS_STATUS, 32'h8, q);
    apb(1'b0, `OFS_STATUS, 32'h0, q);
    chk({31'h0, q[3]}, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      cmd(vram_ctrl_pkg::op_logic_set, 9'h0, 8'h0,
          {4'(c), 8'(c) ^ 8'h96});
      chk({19'h0, vram_model_i.lmode, vram_model_i.lcode,
           vram_model_i.mask}, {19'h0, c != 5, 4'(c), 8'(c) ^ 8'h96});
    end
    apb(1'b1, `OFS_CTRL, 32'h1, q);
    rel();
    n = vram_model_i.cbr_cnt;
    repeat (3900) @(posedge i_clk);
    chk({31'h0, vram_model_i.cbr_cnt - n >= 9}, 32'h1);
    results();
  end
endmodule : vram_ctrl_test
